// file: src/itc_defs.svh
/*
  Constants for the interrupt vector and trap block: source count, register
  offsets, control field positions, trap numbers and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH

// ==========================================================================
// sizes
`define NUM_SRC 50
`define NUM_TRAP 9
`define SRC_IDX_W 6
`define TRAP_NUM_W 7
`define VEC_W 9
`define DATA_W 16
`define ADDR_W 8
`define LVL_W 4

// ==========================================================================
// register offsets (control register n sits at offset n)
`define OFS_TRAP_FLAGS 8'h40
`define OFS_SERVICE 8'h41

// ==========================================================================
// status register fields
`define STAT_RANK_MSB 2
`define STAT_RANK_LSB 0
`define STAT_INT_BIT 3
`define STAT_TRAP_BIT 4

// ==========================================================================
// control register fields
`define CTL_REQ_BIT 7
`define CTL_EN_BIT 6
`define CTL_XFER_BIT 5
`define CTL_LVL_MSB 3
`define CTL_LVL_LSB 0

// ==========================================================================
// source index bases and trap numbers of each group
`define IDX_CC6 6'h00
`define IDX_CC16 6'h0a
`define IDX_CC29 6'h17
`define IDX_T0 6'h1a
`define IDX_T7 6'h1c
`define IDX_T2 6'h1e
`define IDX_CR 6'h23
`define IDX_ADC 6'h24
`define IDX_S0T 6'h26
`define IDX_S0TB 6'h29
`define IDX_SSC 6'h2a
`define IDX_PWM 6'h2d
`define IDX_XP 6'h2e
`define TN_CC6 7'h16
`define TN_CC16 7'h30
`define TN_CC29 7'h44
`define TN_T0 7'h20
`define TN_T7 7'h3d
`define TN_T2 7'h22
`define TN_CR 7'h27
`define TN_ADC 7'h28
`define TN_S0T 7'h2a
`define TN_S0TB 7'h47
`define TN_SSC 7'h2d
`define TN_PWM 7'h3f
`define TN_XP 7'h40

// ==========================================================================
// hardware traps: bit positions in the trap flag register and numbers
`define TBIT_NMI 0
`define TBIT_STKOF 1
`define TBIT_STKUF 2
`define TBIT_CLASS_B 3
`define TN_NMI 7'h02
`define TN_STKOF 7'h04
`define TN_STKUF 7'h06
`define TN_CLASS_B 7'h0a
`define RANK_NONE 3'h0
`define RANK_B 3'h1
`define RANK_STKUF 3'h2
`define RANK_STKOF 3'h3
`define RANK_NMI 3'h4

// ==========================================================================
// reset values
`define RST_LVL 4'h0
`define RST_DATA 16'h0000

`endif

// file: src/itc_pkg.sv
/*
  Types for the interrupt vector and trap block: the packed state record.
  Assumes itc_defs.svh is on the include path.
*/
`include "itc_defs.svh"

package itc_pkg;

  typedef logic [`NUM_SRC-1:0] src_vec_t;
  typedef logic [`LVL_W-1:0] lvl_t;

  // ========================================================================
  // whole state of the block
  typedef struct packed {
    src_vec_t req;
    src_vec_t en;
    src_vec_t xfer;
    logic [`NUM_SRC-1:0][`LVL_W-1:0] lvl;
    logic [`NUM_TRAP-1:0] tflag;
    logic [`NUM_TRAP-1:0] tpend;
    logic [2:0] trank;
    logic int_req;
    logic [`SRC_IDX_W-1:0] int_src;
    logic [`VEC_W-1:0] int_vec;
    logic int_xfer;
    logic trap_req;
    logic [2:0] trap_sel;
    logic [`VEC_W-1:0] trap_vec;
    logic [`DATA_W-1:0] rdata;
  } state_s;

endpackage : itc_pkg

// file: src/interrupt_vector_and_trap_logic.sv
/*
  Interrupt vector assignment and hardware trap logic of the CPU core.
  Assumes peripherals give one-cycle request pulses, the CPU reports its
  current priority level and acknowledges offered services by pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.svh"

module interrupt_vector_and_trap_logic (
  input wire logic clk_sys,
  input wire logic reset,
  input wire itc_pkg::src_vec_t src_event,
  input wire logic [`NUM_TRAP-1:0] trap_event,
  input wire itc_pkg::lvl_t cpu_level,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`DATA_W-1:0] reg_rdata,
  output logic int_req,
  output logic [`VEC_W-1:0] int_vector,
  output logic [`SRC_IDX_W-1:0] int_source,
  output logic int_is_transfer,
  input wire logic int_ack,
  output logic trap_req,
  output logic [`VEC_W-1:0] trap_vector,
  input wire logic trap_ack,
  input wire logic trap_return,
  output logic trap_active
);
  import itc_pkg::*;

  state_s state_reg;
  state_s state_next;

  // ========================================================================
  // trap number of each source
  function automatic logic [`TRAP_NUM_W-1:0] trap_of(input logic [`SRC_IDX_W-1:0] i);
    logic [`TRAP_NUM_W-1:0] t;
    t = `TN_XP + `TRAP_NUM_W'(i - `IDX_XP);
    if (i < `IDX_CC16) begin
      t = `TN_CC6 + `TRAP_NUM_W'(i - `IDX_CC6);
    end else if (i < `IDX_CC29) begin
      t = `TN_CC16 + `TRAP_NUM_W'(i - `IDX_CC16);
    end else if (i < `IDX_T0) begin
      t = `TN_CC29 + `TRAP_NUM_W'(i - `IDX_CC29);
    end else if (i < `IDX_T7) begin
      t = `TN_T0 + `TRAP_NUM_W'(i - `IDX_T0);
    end else if (i < `IDX_T2) begin
      t = `TN_T7 + `TRAP_NUM_W'(i - `IDX_T7);
    end else if (i < `IDX_CR) begin
      t = `TN_T2 + `TRAP_NUM_W'(i - `IDX_T2);
    end else if (i < `IDX_ADC) begin
      t = `TN_CR;
    end else if (i < `IDX_S0T) begin
      t = `TN_ADC + `TRAP_NUM_W'(i - `IDX_ADC);
    end else if (i < `IDX_S0TB) begin
      t = `TN_S0T + `TRAP_NUM_W'(i - `IDX_S0T);
    end else if (i < `IDX_SSC) begin
      t = `TN_S0TB;
    end else if (i < `IDX_PWM) begin
      t = `TN_SSC + `TRAP_NUM_W'(i - `IDX_SSC);
    end else if (i < `IDX_XP) begin
      t = `TN_PWM;
    end
    return t;
  endfunction : trap_of

  // vector slot address from a trap number
  function automatic logic [`VEC_W-1:0] vec_of(input logic [`TRAP_NUM_W-1:0] t);
    return {t, 2'b00};
  endfunction : vec_of

  // ranking of a trap flag bit
  function automatic logic [2:0] rank_of(input int b);
    logic [2:0] r;
    r = `RANK_B;
    if (b == `TBIT_NMI) begin
      r = `RANK_NMI;
    end else if (b == `TBIT_STKOF) begin
      r = `RANK_STKOF;
    end else if (b == `TBIT_STKUF) begin
      r = `RANK_STKUF;
    end
    return r;
  endfunction : rank_of

  // trap number of a trap flag bit
  function automatic logic [`TRAP_NUM_W-1:0] num_of(input int b);
    logic [`TRAP_NUM_W-1:0] n;
    n = `TN_CLASS_B; // shared class B slot
    if (b == `TBIT_NMI) begin
      n = `TN_NMI;
    end else if (b == `TBIT_STKOF) begin
      n = `TN_STKOF;
    end else if (b == `TBIT_STKUF) begin
      n = `TN_STKUF;
    end
    return n;
  endfunction : num_of

  // ========================================================================
  // forwarding mask: request flag and enable flag both set
  src_vec_t src_live;

  generate
    for (genvar g = 0; g < `NUM_SRC; g++) begin : g_live
      assign src_live[g] = state_reg.req[g] & state_reg.en[g];
    end
  endgenerate

  // fixed vector slot of every source
  logic [`VEC_W-1:0] src_vec_tab [`NUM_SRC];

  generate
    for (genvar g = 0; g < `NUM_SRC; g++) begin : g_vec
      assign src_vec_tab[g] = vec_of(trap_of(`SRC_IDX_W'(g)));
    end
  endgenerate

  // vector slot of every trap flag bit
  logic [`VEC_W-1:0] trap_vec_tab [`NUM_TRAP];

  generate
    for (genvar b = 0; b < `NUM_TRAP; b++) begin : g_tvec
      assign trap_vec_tab[b] = vec_of(num_of(b));
    end
  endgenerate

  // ========================================================================
  // interrupt arbitration over enabled pending sources
  logic arb_hit;
  logic [`SRC_IDX_W-1:0] arb_idx;
  lvl_t arb_lvl;

  always_comb begin
    arb_hit = 1'b0;
    arb_idx = '0;
    arb_lvl = cpu_level;
    for (int i = 0; i < `NUM_SRC; i++) begin
      // request and enable both needed, strictly above current level
      if (src_live[i] &&
          state_reg.lvl[i] > arb_lvl) begin
        arb_hit = 1'b1;
        arb_idx = `SRC_IDX_W'(i);
        arb_lvl = state_reg.lvl[i];
      end
    end
  end

  // ========================================================================
  // trap selection: highest rank pending, above the active one
  logic sel_hit;
  logic [2:0] sel_rank;
  logic [`VEC_W-1:0] sel_vec;

  always_comb begin
    sel_hit = 1'b0;
    sel_rank = state_reg.trank;
    sel_vec = trap_vec_tab[`TBIT_CLASS_B];
    for (int b = 0; b < `NUM_TRAP; b++) begin
      if (state_reg.tpend[b] && rank_of(b) > sel_rank) begin
        sel_hit = 1'b1;
        sel_rank = rank_of(b);
        sel_vec = trap_vec_tab[b];
      end
    end
  end

  // ========================================================================
  // handshake events and hold-off seen at this edge
  logic int_taken;
  logic trap_taken;
  logic svc_idle;
  logic int_hold;

  assign int_taken = int_ack && state_reg.int_req; // offer accepted
  assign trap_taken = trap_ack && state_reg.trap_req; // trap service entered
  assign svc_idle = state_reg.trank == `RANK_NONE; // no trap in service
  // a pending or running trap keeps interrupts and transfers away
  assign int_hold = !svc_idle || sel_hit;

  // ========================================================================
  // next state
  always_comb begin
    logic [`SRC_IDX_W-1:0] wi;
    wi = reg_addr[`SRC_IDX_W-1:0];
    state_next = state_reg;
    state_next.rdata = `RST_DATA;

    // register writes first, so hardware sets below win
    if (reg_write) begin
      if (reg_addr < `ADDR_W'(`NUM_SRC)) begin
        state_next.req[wi] = reg_wdata[`CTL_REQ_BIT];
        state_next.en[wi] = reg_wdata[`CTL_EN_BIT];
        state_next.xfer[wi] = reg_wdata[`CTL_XFER_BIT];
        state_next.lvl[wi] = reg_wdata[`CTL_LVL_MSB:`CTL_LVL_LSB];
      end else if (reg_addr == `OFS_TRAP_FLAGS) begin
        // write one clears a flag
        state_next.tflag = state_reg.tflag & ~reg_wdata[`NUM_TRAP-1:0];
      end
    end

    // read data for the next cycle
    if (reg_read) begin
      if (reg_addr < `ADDR_W'(`NUM_SRC)) begin
        state_next.rdata[`CTL_REQ_BIT] = state_reg.req[wi];
        state_next.rdata[`CTL_EN_BIT] = state_reg.en[wi];
        state_next.rdata[`CTL_XFER_BIT] = state_reg.xfer[wi];
        state_next.rdata[`CTL_LVL_MSB:`CTL_LVL_LSB] = state_reg.lvl[wi];
      end else if (reg_addr == `OFS_TRAP_FLAGS) begin
        state_next.rdata[`NUM_TRAP-1:0] = state_reg.tflag;
      end else if (reg_addr == `OFS_SERVICE) begin
        state_next.rdata[`STAT_RANK_MSB:`STAT_RANK_LSB] = state_reg.trank;
        state_next.rdata[`STAT_INT_BIT] = state_reg.int_req;
        state_next.rdata[`STAT_TRAP_BIT] = state_reg.trap_req;
      end
    end

    // accepted interrupt or transfer clears its request flag
    if (int_taken) begin
      state_next.req[state_reg.int_src] = 1'b0;
    end

    // peripheral events set request flags
    state_next.req = state_next.req | src_event;

    // accepted trap: enter service, drop pending bits of its rank
    if (trap_return) begin
      state_next.trank = `RANK_NONE;
    end
    if (trap_taken) begin
      state_next.trank = state_reg.trap_sel;
      for (int b = 0; b < `NUM_TRAP; b++) begin
        if (rank_of(b) == state_reg.trap_sel) begin
          state_next.tpend[b] = 1'b0;
        end
      end
    end

    // trap events: unmaskable, flag and pending both set
    state_next.tflag = state_next.tflag | trap_event;
    state_next.tpend = state_next.tpend | trap_event;

    // registered trap offer to the CPU
    state_next.trap_req = sel_hit && !trap_taken;
    state_next.trap_sel = sel_rank;
    state_next.trap_vec = sel_vec;

    // interrupt offer, held off by trap service or pending trap
    state_next.int_req = arb_hit && !int_hold && !int_taken;
    state_next.int_src = arb_idx;
    state_next.int_vec = src_vec_tab[arb_idx];
    state_next.int_xfer = state_reg.xfer[arb_idx];
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // outputs
  assign reg_rdata = state_reg.rdata;
  assign int_req = state_reg.int_req;
  assign int_vector = state_reg.int_vec;
  assign int_source = state_reg.int_src;
  assign int_is_transfer = state_reg.int_xfer;
  assign trap_req = state_reg.trap_req;
  assign trap_vector = state_reg.trap_vec;
  assign trap_active = state_reg.trank != `RANK_NONE;

endmodule : interrupt_vector_and_trap_logic

`default_nettype wire

// file: verif/ivt_cpu_model.sv
/*
  Cpu side model: takes interrupt and trap offers, ends trap services.
  Assumes the offer handshake of the interrupt vector and trap block.
*/
`timescale 1ns/1ps
`default_nettype none
module ivt_cpu_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic slow,
  input wire logic int_req,
  input wire logic trap_req,
  input wire logic trap_active,
  output logic int_ack,
  output logic trap_ack,
  output logic trap_return
);
  // ==========================================================================
  // handshake
  int wait_cnt;
  int svc_cnt;
  // ack at once or after 3 cycles; a trap service lasts 32 cycles
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_cnt <= 0;
      svc_cnt <= 0;
      int_ack <= 1'b0;
      trap_ack <= 1'b0;
      trap_return <= 1'b0;
    end else begin
      int_ack <= int_req && !int_ack && wait_cnt >= (slow ? 3 : 0);
      wait_cnt <= (int_req && !int_ack) ? wait_cnt + 1 : 0;
      trap_ack <= trap_req && !trap_ack;
      svc_cnt <= trap_active ? svc_cnt + 1 : 0;
      trap_return <= (svc_cnt == 30);
    end
  end
endmodule : ivt_cpu_model
`default_nettype wire

// file: verif/interrupt_vector_and_trap_logic_properties.sv
/*
  Checker of offers and traps at the ports of the vector and trap block.
  Assumes itc_defs.svh on the include path; bound below its endmodule.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.svh"
module interrupt_vector_and_trap_logic_properties (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [`NUM_TRAP-1:0] trap_event,
  input wire logic int_req,
  input wire logic [`VEC_W-1:0] int_vector,
  input wire logic [`SRC_IDX_W-1:0] int_source,
  input wire logic int_is_transfer,
  input wire logic int_ack,
  input wire logic trap_req,
  input wire logic [`VEC_W-1:0] trap_vector,
  input wire logic trap_active
);
  // ==========================================================================
  // vectors of offered sources
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_cc_low_vector: assert property (
    int_req && int_source <= 6'h09 |-> int_vector == {int_source + 7'h16, 2'b00})
    else $error("capture channel 6-15 vector wrong");
  a_cc_mid_vector: assert property (
    int_req && int_source inside {[6'h0a:6'h16]} |-> int_vector == {int_source + 7'h26, 2'b00})
    else $error("capture channel 16-28 vector wrong");
  a_cc_high_vector: assert property (
    int_req && int_source inside {[6'h17:6'h19]} |-> int_vector == {int_source + 7'h2d, 2'b00})
    else $error("capture channel 29-31 vector wrong");
  a_pwm_shared_vector: assert property (
    int_req && int_source == 6'h2d |-> int_vector == 9'h0fc)
    else $error("pwm vector wrong");
  a_ext_line_vector: assert property (
    int_req && int_source >= 6'h2e |-> int_vector == {int_source + 7'h12, 2'b00})
    else $error("extension line vector wrong");
  // ==========================================================================
  // traps and their interplay with offers
  a_nmi_unmasked_offer: assert property (
    trap_event[0] && !trap_active && !trap_req |-> ##2 trap_req && trap_vector == 9'h008)
    else $error("nmi not offered two cycles after its event");
  a_trap_blocks_int: assert property (
    $rose(int_req) |-> !$past(trap_active))
    else $error("interrupt offered during trap service");
  a_trap_vector_slot: assert property (
    trap_req |-> trap_vector inside {9'h008, 9'h010, 9'h018, 9'h028})
    else $error("trap vector outside trap slots");
  a_transfer_one_cycle: assert property (
    int_req && int_ack && int_is_transfer |=> !int_req)
    else $error("event transfer held longer than one cycle");
endmodule : interrupt_vector_and_trap_logic_properties
bind interrupt_vector_and_trap_logic interrupt_vector_and_trap_logic_properties u_props (
  .clk_sys, .reset, .trap_event, .int_req, .int_vector, .int_source, .int_is_transfer,
  .int_ack, .trap_req, .trap_vector, .trap_active);
`default_nettype wire

// file: verif/interrupt_vector_and_trap_logic_bench.sv
/*
  Self-checking bench of the vector and trap block with a cpu side model.
  Assumes itc_defs.svh on the include path and the checker bound in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.svh"
module interrupt_vector_and_trap_logic_bench;
  import itc_pkg::*;
  logic clk_sys, reset, reg_write, reg_read, slow, int_req, int_is_transfer, int_ack;
  logic trap_req, trap_ack, trap_return, trap_active;
  logic [`VEC_W-1:0] int_vector, trap_vector;
  logic [`SRC_IDX_W-1:0] int_source;
  logic [15:0] reg_rdata, reg_wdata;
  logic [7:0] reg_addr;
  src_vec_t src_event;
  lvl_t cpu_level;
  logic [`NUM_TRAP-1:0] trap_event;
  int mismatches = 0;
  int tests_run = 0;
  // ==========================================================================
  // design and cpu side
  interrupt_vector_and_trap_logic u_dut (.clk_sys, .reset, .src_event, .trap_event,
    .cpu_level, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .int_req,
    .int_vector, .int_source, .int_is_transfer, .int_ack, .trap_req, .trap_vector,
    .trap_ack, .trap_return, .trap_active);
  ivt_cpu_model u_cpu (.clk_sys, .reset, .slow, .int_req, .trap_req, .trap_active,
    .int_ack, .trap_ack, .trap_return);
  // clock of 100 ns
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // helpers
  function automatic int tn_of(input int i);
    if (i < 10) return i + 'h16;
    if (i < 23) return i + 'h26;
    if (i < 26) return i + 'h2d;
    if (i < 28) return i + 'h06;
    if (i < 30) return i + 'h21;
    if (i < 41) return i + 4;
    if (i == 41) return 'h47;
    if (i < 45) return i + 3;
    if (i == 45) return 'h3f;
    return i + 'h12;
  endfunction : tn_of
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd
  task automatic pulse(input src_vec_t s, input logic [`NUM_TRAP-1:0] t);
    @(posedge clk_sys);
    src_event <= s;
    trap_event <= t;
    @(posedge clk_sys);
    src_event <= '0;
    trap_event <= '0;
  endtask : pulse
  task automatic expect_int(input int src, input logic xf);
    int n = 0;
    while (int_req !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk("int_req", 16'h0001, 16'(int_req));
    chk("int_vector", 16'(tn_of(src) * 4), 16'(int_vector));
    chk("int_source", 16'(src), 16'(int_source));
    chk("int_is_transfer", 16'(xf), 16'(int_is_transfer));
    while (int_req === 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("int_req", 16'h0000, 16'(int_req));
  endtask : expect_int
  task automatic expect_trap(input logic [15:0] vec);
    int n = 0;
    while (trap_req !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk("trap_req", 16'h0001, 16'(trap_req));
    chk("trap_vector", vec, 16'(trap_vector));
  endtask : expect_trap
  task automatic wait_idle();
    int n = 0;
    repeat (3) @(negedge clk_sys);
    while (trap_active === 1'b1 && n < 80) begin
      @(negedge clk_sys);
      n++;
    end
    chk("trap_active", 16'h0000, 16'(trap_active));
  endtask : wait_idle
  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // tests
  initial begin
    reset = 1'b1;
    {reg_write, reg_read, slow, reg_addr, reg_wdata, cpu_level} = '0;
    src_event = '0;
    trap_event = '0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h31, 16'h0000);
    rd(8'h7f, 16'h0000);
    // each source held off while disabled, then vectored once enabled
    for (int i = 0; i < 50; i++) begin
      wr(8'(i), 16'h0001);
      pulse(src_vec_t'(1) << i, '0);
      repeat (3) @(negedge clk_sys);
      chk("int_req", 16'h0000, 16'(int_req));
      rd(8'(i), 16'h0081);
      wr(8'(i), 16'h00c1);
      expect_int(i, 1'b0);
      rd(8'(i), 16'h0041);
    end
    // higher level first, then against the cpu level, with slow acks
    wr(8'h00, 16'h0042);
    wr(8'h01, 16'h0049);
    slow <= 1'b1;
    pulse(src_vec_t'(3), '0);
    expect_int(1, 1'b0);
    expect_int(0, 1'b0);
    @(posedge clk_sys);
    cpu_level <= 4'h2;
    pulse(src_vec_t'(1), '0);
    repeat (4) @(negedge clk_sys);
    chk("int_req", 16'h0000, 16'(int_req));
    @(posedge clk_sys);
    cpu_level <= 4'h0;
    expect_int(0, 1'b0);
    wr(8'h03, 16'h0061);
    pulse(src_vec_t'(8), '0);
    expect_int(3, 1'b1);
    // stack trap, blocked interrupt, nmi preemption, class b
    pulse('0, 9'h002);
    expect_trap(16'h0010);
    pulse(src_vec_t'(4), '0);
    repeat (4) @(negedge clk_sys);
    chk("int_req", 16'h0000, 16'(int_req));
    chk("trap_active", 16'h0001, 16'(trap_active));
    rd(8'h40, 16'h0002);
    rd(8'h41, 16'h0003);
    pulse('0, 9'h001);
    expect_trap(16'h0008);
    wait_idle();
    expect_int(2, 1'b0);
    rd(8'h40, 16'h0003);
    wr(8'h40, 16'h0003);
    rd(8'h40, 16'h0000);
    pulse('0, 9'h001);
    expect_trap(16'h0008);
    wait_idle();
    pulse('0, 9'h020);
    expect_trap(16'h0028);
    wait_idle();
    rd(8'h40, 16'h0021);
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    repeat (10000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end
endmodule : interrupt_vector_and_trap_logic_bench
`default_nettype wire
